// >>> mtr_consts.svh
// Offsets, field positions, reset values and sizes for the memory-type range block
`ifndef MTR_CONSTS_SVH
`define MTR_CONSTS_SVH

`define MTR_IDX_W           12
`define MTR_IDX_CAP         12'h000
`define MTR_IDX_DEF         12'h001
`define MTR_IDX_FIX0        12'h010
`define MTR_IDX_VAR0        12'h020
`define MTR_FIX_N           12'd11
`define MTR_VAR_N           12'd16
`define MTR_VAR_BASE_SLOT   5'd11
`define MTR_SLOT_N          27
`define MTR_RANGE_COUNT     96

`define MTR_CAP_VALUE       64'h0000_0000_0000_0508
`define MTR_CAP_VARIABLE_RANGE_COUNT        8'h08
`define MTR_CAP_FIX_BIT     8
`define MTR_CAP_WC_BIT      10

`define MTR_DEF_FE_BIT      10
`define MTR_DEF_E_BIT       11
`define MTR_DEF_RSV_MASK    64'hffff_ffff_ffff_f300

`define MTR_TYPE_UC         8'h00
`define MTR_TYPE_WC         8'h01
`define MTR_TYPE_WT         8'h04
`define MTR_TYPE_WP         8'h05
`define MTR_TYPE_WB         8'h06

`define MTR_CR0_PE          0
`define MTR_CR0_PG          31
`define MTR_CR4_PSE         4
`define MTR_CR4_PAE         5
`define MTR_CR4_PGE         7

`define MTR_FEAT_RANGE_BIT  12
`define MTR_FEATURE_WORD    32'h0000_1000

`define MTR_PAGE_W          20
`define MTR_PAGE_LSB        12
`define MTR_TLB_N           8
`define MTR_TLB_IDX_W       3

`endif

// >>> mtr_pkg.sv
// Types shared by the memory-type range block and its translation buffer
`include "mtr_consts.svh"
package mtr_pkg;

	typedef enum logic [3:0] {
		MTR_OP_NONE,
		MTR_OP_MODEL_RD,
		MTR_OP_MODEL_WR,
		MTR_OP_CR0_WR,
		MTR_OP_CR3_WR,
		MTR_OP_TASK_SWITCH,
		MTR_OP_CR4_WR,
		MTR_OP_PAGE_INV,
		MTR_OP_TYPE_CHECK
	} mtr_op_t;

	typedef enum logic [2:0] {
		MTR_MT_UNCACHEABLE,
		MTR_MT_WRITE_COMBINING,
		MTR_MT_WRITE_THROUGH,
		MTR_MT_WRITE_PROTECT,
		MTR_MT_WRITEBACK,
		MTR_MT_RESERVED
	} mtr_memtype_t;

	typedef struct packed {
		logic                  valid;
		mtr_op_t               op;
		logic [`MTR_IDX_W-1:0] index;
		logic [63:0]           data;
	} mtr_cmd_t;

	typedef struct packed {
		logic                   valid;
		logic                   isGlobal;
		logic [`MTR_PAGE_W-1:0] vpage;
		logic [`MTR_PAGE_W-1:0] frame;
	} mtr_fill_t;

	typedef mtr_fill_t mtr_tlb_entry_t;

	typedef struct packed {
		mtr_tlb_entry_t [`MTR_TLB_N-1:0] ent;
		logic [`MTR_TLB_IDX_W-1:0]       nextSlot;
		logic                            hit;
		logic [`MTR_PAGE_W-1:0]          frame;
		logic                            isGlobal;
	} mtr_tlb_state_t;

	typedef struct packed {
		logic [63:0]                    defType;
		logic [`MTR_SLOT_N-1:0][63:0]   ranges;
		logic                           fixedOn;
		logic [31:0]                    cr0;
		logic [31:0]                    cr3;
		logic [31:0]                    cr4;
		logic                           pinPrev;
		logic [63:0]                    rdData;
		logic                           rdValid;
		logic                           fault;
		logic                           typeValid;
		mtr_memtype_t                   memType;
		logic [31:0]                    feature;
	} mtr_core_state_t;

endpackage

// >>> mtr_tlb.sv
// Translation buffer with per-entry global flag and three flush flavours
`timescale 1ns/1ns
`include "mtr_consts.svh"
module mtr_tlb
	import mtr_pkg::*;
(
	input  wire logic                   sys_clk,        // Core clock
	input  wire logic                   rst,            // Async reset, high
	input  wire logic                   flushAll,       // Drop every entry
	input  wire logic                   flushNonGlobal, // Drop non-global entries
	input  wire logic                   flushPage,      // Drop one page
	input  wire logic [`MTR_PAGE_W-1:0] pageAddr,       // Page for flushPage
	input  wire mtr_fill_t              fill,           // New translation
	input  wire logic [`MTR_PAGE_W-1:0] lookupPage,     // Page to translate
	output logic                        hit,            // Lookup hit
	output logic [`MTR_PAGE_W-1:0]      frame,          // Lookup frame
	output logic                        isGlobal        // Lookup global flag
);

	mtr_tlb_state_t             st_q;
	mtr_tlb_state_t             st_d;
	logic [3:0]                 fillHit;
	logic [3:0]                 look;
	logic [`MTR_TLB_IDX_W-1:0]  slotSel;
	logic [`MTR_TLB_N-1:0]      validVec;
	logic [`MTR_TLB_N-1:0]      globalVec;

	function automatic logic [3:0] findPage(input mtr_tlb_entry_t [`MTR_TLB_N-1:0] e,
		input logic [`MTR_PAGE_W-1:0] p);
		findPage = 4'h0;
		for (int i = 0; i < `MTR_TLB_N; i++) begin
			if (e[i].valid && e[i].vpage == p) begin
				findPage = {1'b1, i[2:0]};
			end
		end
	endfunction

	// A call result cannot be bit-selected, so the hit flag comes through here
	function automatic logic pageHeld(input mtr_tlb_entry_t [`MTR_TLB_N-1:0] e,
		input logic [`MTR_PAGE_W-1:0] p);
		logic [3:0] f;
		f = findPage(e, p);
		pageHeld = f[3];
	endfunction

	always_comb begin
		st_d = st_q;
		for (int i = 0; i < `MTR_TLB_N; i++) begin
			if (flushAll) begin
				st_d.ent[i].valid = 1'b0;
			end
			if (flushNonGlobal && !st_q.ent[i].isGlobal) begin
				st_d.ent[i].valid = 1'b0;
			end
			if (flushPage && st_q.ent[i].vpage == pageAddr) begin
				st_d.ent[i].valid = 1'b0;
			end
		end
		// Fill lands after the flush so a refill in the same cycle survives
		fillHit = findPage(st_d.ent, fill.vpage);
		slotSel = fillHit[3] ? fillHit[2:0] : st_q.nextSlot;
		if (fill.valid) begin
			st_d.ent[slotSel] = fill;
			if (!fillHit[3]) begin
				st_d.nextSlot = st_q.nextSlot + 3'h1;
			end
		end
		look = findPage(st_q.ent, lookupPage);
		st_d.hit = look[3];
		st_d.frame = st_q.ent[look[2:0]].frame;
		st_d.isGlobal = st_q.ent[look[2:0]].isGlobal;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign hit = st_q.hit;
	assign frame = st_q.frame;
	assign isGlobal = st_q.isGlobal;

	always_comb begin
		for (int i = 0; i < `MTR_TLB_N; i++) begin
			validVec[i] = st_q.ent[i].valid;
			globalVec[i] = st_q.ent[i].isGlobal;
		end
	end

	default clocking cbTlb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_full_clear: assert property (flushAll && !fill.valid |=> validVec == '0)
		else $error("full flush left an entry valid");
	chk_keep_global: assert property (
		flushNonGlobal && !flushAll && !flushPage && !fill.valid
		|=> validVec == $past(validVec & globalVec))
		else $error("selective flush mishandled global entries");
	chk_page_gone: assert property (flushPage && !fill.valid
		|=> !pageHeld(st_q.ent, $past(pageAddr)))
		else $error("invalidated page still present");

endmodule

// >>> mtr_top.sv
// Memory-type range registers, capability reporting and translation flush control
`timescale 1ns/1ns
`include "mtr_consts.svh"
module mtr_top
	import mtr_pkg::*;
(
	input  wire logic                   sys_clk,      // Core clock, 10 MHz
	input  wire logic                   rst,          // Async reset, high
	input  wire mtr_cmd_t               cmd,          // Command from the core
	input  wire logic                   flushPinN,    // External flush pin, a change in either direction flushes
	input  wire mtr_fill_t              fill,         // Translation fill
	input  wire logic [`MTR_PAGE_W-1:0] lookupPage,   // Page to translate
	output logic [63:0]                 rdData,       // Model register read data
	output logic                        rdValid,      // Read data valid pulse
	output logic                        fault,        // Protection fault pulse
	output mtr_memtype_t                memType,      // Decoded memory type
	output logic                        typeValid,    // memType valid pulse
	output logic                        rangesOn,     // Range mechanism enabled
	output logic                        fixedOn,      // Fixed ranges in effect
	output logic [31:0]                 featureWord,  // Identify feature word
	output logic                        lookupHit,    // Translation hit
	output logic [`MTR_PAGE_W-1:0]      lookupFrame,  // Translated frame
	output logic                        lookupGlobal  // Hit entry is global
);

	mtr_core_state_t  st_q;
	mtr_core_state_t  st_d;
	logic             flushAll;
	logic             flushNonGlobal;
	logic             flushPage;
	logic [5:0]       slotHit;
	logic [4:0]       slot;
	logic [4:0]       varOff;
	logic             isFixed;
	logic             isBase;
	logic             wrOk;
	logic             defOk;

	function automatic logic typeLegal(input logic [7:0] t);
		case (t)
			`MTR_TYPE_UC,
			`MTR_TYPE_WC,
			`MTR_TYPE_WT,
			`MTR_TYPE_WP,
			`MTR_TYPE_WB: typeLegal = 1'b1;
			default: typeLegal = 1'b0;
		endcase
	endfunction

	function automatic mtr_memtype_t decodeType(input logic [7:0] t);
		case (t)
			`MTR_TYPE_UC: decodeType = MTR_MT_UNCACHEABLE;
			`MTR_TYPE_WC: decodeType = MTR_MT_WRITE_COMBINING;
			`MTR_TYPE_WT: decodeType = MTR_MT_WRITE_THROUGH;
			`MTR_TYPE_WP: decodeType = MTR_MT_WRITE_PROTECT;
			`MTR_TYPE_WB: decodeType = MTR_MT_WRITEBACK;
			default: decodeType = MTR_MT_RESERVED;
		endcase
	endfunction

	// A fixed register packs eight type bytes; every one must be legal
	function automatic logic fixedOk(input logic [63:0] v);
		fixedOk = 1'b1;
		for (int b = 0; b < 8; b++) begin
			if (!typeLegal(v[b*8 +: 8])) begin
				fixedOk = 1'b0;
			end
		end
	endfunction

	// Bit 5 flags a hit; low bits give the storage slot
	function automatic logic [5:0] slotOf(input logic [`MTR_IDX_W-1:0] idx);
		logic [`MTR_IDX_W-1:0] off;
		off = '0;
		slotOf = 6'h00;
		if (idx >= `MTR_IDX_FIX0 && idx < `MTR_IDX_FIX0 + `MTR_FIX_N) begin
			off = idx - `MTR_IDX_FIX0;
			slotOf = {1'b1, off[4:0]};
		end else if (idx >= `MTR_IDX_VAR0 && idx < `MTR_IDX_VAR0 + `MTR_VAR_N) begin
			off = idx - `MTR_IDX_VAR0;
			slotOf = {1'b1, off[4:0] + `MTR_VAR_BASE_SLOT};
		end
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.rdValid = 1'b0;
		st_d.fault = 1'b0;
		st_d.typeValid = 1'b0;
		st_d.pinPrev = flushPinN;
		// The pin is a level; any change in either direction flushes
		flushAll = (flushPinN != st_q.pinPrev);
		flushNonGlobal = 1'b0;
		flushPage = 1'b0;
		// 11 fixed registers of 8 ranges plus 8 variable pairs
		slotHit = slotOf(cmd.index);
		slot = slotHit[4:0];
		varOff = slot - `MTR_VAR_BASE_SLOT;
		isFixed = slot < `MTR_VAR_BASE_SLOT;
		isBase = !isFixed && !varOff[0];
		wrOk = isFixed ? fixedOk(cmd.data) : (!isBase || typeLegal(cmd.data[7:0]));
		defOk = typeLegal(cmd.data[7:0]) && ((cmd.data & `MTR_DEF_RSV_MASK) == 64'h0);
		if (cmd.valid) begin
			case (cmd.op)
				MTR_OP_MODEL_RD: begin
					st_d.rdValid = 1'b1;
					if (cmd.index == `MTR_IDX_CAP) begin
						st_d.rdData = `MTR_CAP_VALUE;
					end else if (cmd.index == `MTR_IDX_DEF) begin
						st_d.rdData = st_q.defType;
					end else if (slotHit[5]) begin
						st_d.rdData = st_q.ranges[slot];
					end else begin
						st_d.rdValid = 1'b0;
						st_d.fault = 1'b1;
					end
				end
				MTR_OP_MODEL_WR: begin
					if (cmd.index == `MTR_IDX_CAP) begin
						st_d.fault = 1'b1;
					end else if (cmd.index == `MTR_IDX_DEF && defOk) begin
						st_d.defType = cmd.data;
						flushAll = 1'b1;
					end else if (cmd.index != `MTR_IDX_DEF && slotHit[5] && wrOk) begin
						st_d.ranges[slot] = cmd.data;
						flushAll = 1'b1;
					end else begin
						// Refused writes store nothing and so flush nothing
						st_d.fault = 1'b1;
					end
				end
				MTR_OP_CR0_WR: begin
					if (cmd.data[`MTR_CR0_PG] != st_q.cr0[`MTR_CR0_PG] ||
						cmd.data[`MTR_CR0_PE] != st_q.cr0[`MTR_CR0_PE]) begin
						flushAll = 1'b1;
					end
					st_d.cr0 = cmd.data[31:0];
				end
				MTR_OP_CR3_WR: begin
					flushNonGlobal = 1'b1;
					st_d.cr3 = cmd.data[31:0];
				end
				MTR_OP_TASK_SWITCH: begin
					if (cmd.data[31:0] != st_q.cr3) begin
						flushNonGlobal = 1'b1;
					end
					st_d.cr3 = cmd.data[31:0];
				end
				MTR_OP_CR4_WR: begin
					if (cmd.data[`MTR_CR4_PSE] != st_q.cr4[`MTR_CR4_PSE] ||
						cmd.data[`MTR_CR4_PGE] != st_q.cr4[`MTR_CR4_PGE] ||
						cmd.data[`MTR_CR4_PAE] != st_q.cr4[`MTR_CR4_PAE]) begin
						flushAll = 1'b1;
					end
					st_d.cr4 = cmd.data[31:0];
				end
				MTR_OP_PAGE_INV: begin
					flushPage = 1'b1;
				end
				MTR_OP_TYPE_CHECK: begin
					st_d.memType = decodeType(cmd.data[7:0]);
					st_d.typeValid = 1'b1;
					st_d.fault = !typeLegal(cmd.data[7:0]);
				end
				default: begin
				end
			endcase
		end
		// The fixed-enable flag only counts while the whole mechanism is on
		st_d.fixedOn = st_d.defType[`MTR_DEF_E_BIT] && st_d.defType[`MTR_DEF_FE_BIT];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.pinPrev <= 1'b1;
			st_q.feature <= `MTR_FEATURE_WORD;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdData = st_q.rdData;
	assign rdValid = st_q.rdValid;
	assign fault = st_q.fault;
	assign memType = st_q.memType;
	assign typeValid = st_q.typeValid;
	assign rangesOn = st_q.defType[`MTR_DEF_E_BIT];
	assign fixedOn = st_q.fixedOn;
	assign featureWord = st_q.feature;

	mtr_tlb u_tlb (
		.sys_clk        (sys_clk),
		.rst            (rst),
		.flushAll       (flushAll),
		.flushNonGlobal (flushNonGlobal),
		.flushPage      (flushPage),
		.pageAddr       (cmd.data[`MTR_PAGE_LSB +: `MTR_PAGE_W]),
		.fill           (fill),
		.lookupPage     (lookupPage),
		.hit            (lookupHit),
		.frame          (lookupFrame),
		.isGlobal       (lookupGlobal)
	);

	default clocking cbTop @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_cap_read: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_RD && cmd.index == `MTR_IDX_CAP
		|=> rdValid && !fault && rdData == `MTR_CAP_VALUE)
		else $error("capability read returned wrong value");

	chk_cap_fields: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_RD && cmd.index == `MTR_IDX_CAP
		|=> rdData[7:0] == `MTR_CAP_VARIABLE_RANGE_COUNT && rdData[`MTR_CAP_FIX_BIT]
			&& rdData[`MTR_CAP_WC_BIT])
		else $error("capability fields wrong");

	chk_cap_reserved: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_RD && cmd.index == `MTR_IDX_CAP
		|=> rdData[9] == 1'b0 && rdData[63:11] == '0)
		else $error("capability reserved bits not zero");

	chk_cap_write: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_WR && cmd.index == `MTR_IDX_CAP
		|-> !flushAll || flushPinN != st_q.pinPrev ##1 fault && !rdValid)
		else $error("capability write not refused");

	chk_type_wb: assert property (
		cmd.valid && cmd.op == MTR_OP_TYPE_CHECK && cmd.data[7:0] == `MTR_TYPE_WB
		|=> typeValid && !fault && memType == MTR_MT_WRITEBACK)
		else $error("writeback code misdecoded");

	chk_type_wc: assert property (
		cmd.valid && cmd.op == MTR_OP_TYPE_CHECK && cmd.data[7:0] == `MTR_TYPE_WC
		|=> typeValid && !fault && memType == MTR_MT_WRITE_COMBINING)
		else $error("write-combining code misdecoded");

	chk_type_reserved: assert property (
		cmd.valid && cmd.op == MTR_OP_TYPE_CHECK && !typeLegal(cmd.data[7:0])
		|=> typeValid && fault && memType == MTR_MT_RESERVED)
		else $error("reserved type code not faulted");

	chk_pin_flush: assert property ($changed(flushPinN) |-> flushAll)
		else $error("flush pin edge did not flush");

	chk_range_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_WR && flushPinN == st_q.pinPrev
		|=> fault != $past(flushAll))
		else $error("range write flush and fault disagree");

	chk_cr0_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_CR0_WR
		&& cmd.data[`MTR_CR0_PG] != st_q.cr0[`MTR_CR0_PG]
		|-> flushAll)
		else $error("paging flag change did not flush");

	chk_cr4_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_CR4_WR
		&& cmd.data[`MTR_CR4_PGE] != st_q.cr4[`MTR_CR4_PGE]
		|-> flushAll)
		else $error("global-page flag change did not flush");

	chk_base_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_CR3_WR |-> flushNonGlobal && !flushPage)
		else $error("base register write did not flush");

	chk_reset_off: assert property ($fell(rst) |-> !rangesOn && !fixedOn)
		else $error("ranges enabled after reset");

	chk_feature_bit: assert property (featureWord[`MTR_FEAT_RANGE_BIT])
		else $error("feature bit for ranges clear");

	chk_pe_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_CR0_WR
		&& cmd.data[`MTR_CR0_PE] != st_q.cr0[`MTR_CR0_PE]
		|-> flushAll)
		else $error("protection flag change did not flush");

	chk_size_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_CR4_WR
		&& (cmd.data[`MTR_CR4_PSE] != st_q.cr4[`MTR_CR4_PSE]
		|| cmd.data[`MTR_CR4_PAE] != st_q.cr4[`MTR_CR4_PAE])
		|-> flushAll)
		else $error("large-page or address flag change did not flush");

	chk_task_flush: assert property (
		cmd.valid && cmd.op == MTR_OP_TASK_SWITCH && cmd.data[31:0] != st_q.cr3
		|-> flushNonGlobal && !flushPage)
		else $error("task switch did not flush");

	chk_page_flush: assert property (cmd.valid && cmd.op == MTR_OP_PAGE_INV
		|-> flushPage && !flushNonGlobal)
		else $error("page invalidate did not flush one page");

	chk_type_wt: assert property (
		cmd.valid && cmd.op == MTR_OP_TYPE_CHECK && cmd.data[7:0] == `MTR_TYPE_WT
		|=> typeValid && !fault && memType == MTR_MT_WRITE_THROUGH)
		else $error("write-through code misdecoded");

	chk_type_wp: assert property (
		cmd.valid && cmd.op == MTR_OP_TYPE_CHECK && cmd.data[7:0] == `MTR_TYPE_WP
		|=> typeValid && !fault && memType == MTR_MT_WRITE_PROTECT)
		else $error("write-protected code misdecoded");

	chk_type_uc: assert property (
		cmd.valid && cmd.op == MTR_OP_TYPE_CHECK && cmd.data[7:0] == `MTR_TYPE_UC
		|=> typeValid && !fault && memType == MTR_MT_UNCACHEABLE)
		else $error("uncacheable code misdecoded");

	chk_def_store: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_WR && cmd.index == `MTR_IDX_DEF
		&& typeLegal(cmd.data[7:0]) && (cmd.data & `MTR_DEF_RSV_MASK) == 64'h0
		|=> rangesOn == $past(cmd.data[`MTR_DEF_E_BIT]))
		else $error("default type write not stored");

	chk_def_type_bad: assert property (
		cmd.valid && cmd.op == MTR_OP_MODEL_WR && cmd.index == `MTR_IDX_DEF
		&& !typeLegal(cmd.data[7:0])
		|=> fault)
		else $error("illegal default type not faulted");

endmodule

// >>> mtr_core_model.sv
// Core-side model that issues commands, fills, lookups and flush-pin moves
`timescale 1ns/1ns
`include "mtr_consts.svh"
module mtr_core_model
	import mtr_pkg::*;
(
	input  wire logic              sys_clk,    // Core clock
	output mtr_cmd_t               cmd,        // Command to the block
	output mtr_fill_t              fill,       // Translation fill
	output logic [`MTR_PAGE_W-1:0] lookupPage, // Page to translate
	output logic                   flushPinN   // External flush pin, a change in either direction flushes
);
	initial begin
		cmd = '0;
		fill = '0;
		lookupPage = '0;
		flushPinN = 1'b1;
	end

	// Released fields show the inverse so a stale value cannot pass for a live one
	task automatic issue(input mtr_op_t op, input logic [11:0] idx, input logic [63:0] data);
		@(posedge sys_clk);
		cmd <= '{valid: 1'b1, op: op, index: idx, data: data};
		@(posedge sys_clk);
		cmd <= '{valid: 1'b0, op: MTR_OP_NONE, index: ~idx, data: ~data};
	endtask

	task automatic put(input logic g, input logic [19:0] pg, input logic [19:0] fr);
		@(posedge sys_clk);
		fill <= '{valid: 1'b1, isGlobal: g, vpage: pg, frame: fr};
		@(posedge sys_clk);
		fill <= '{valid: 1'b0, isGlobal: ~g, vpage: ~pg, frame: ~fr};
	endtask

	task automatic look(input logic [19:0] pg);
		@(posedge sys_clk);
		lookupPage <= pg;
		@(posedge sys_clk);
	endtask

	// The level is seen one edge later, so return after that edge
	task automatic pin(input logic lvl);
		@(posedge sys_clk);
		flushPinN <= lvl;
		@(posedge sys_clk);
	endtask
endmodule

// >>> mtr_top_tb.sv
// Self-checking bench for the memory-type range block
`timescale 1ns/1ns
`include "mtr_consts.svh"
module mtr_top_tb
	import mtr_pkg::*;
;
	typedef struct {
		mtr_op_t     op;
		logic [11:0] idx;
		logic [63:0] data;
		logic        expFault;
		logic [63:0] expVal;
	} mtr_reg_row_t;

	typedef struct {
		mtr_op_t     op;
		logic [11:0] idx;
		logic [63:0] data;
		logic        expG;
		logic        expN;
	} mtr_flush_row_t;

	localparam logic [19:0] PG_G = 20'h12345;
	localparam logic [19:0] PG_N = 20'h0abcd;
	localparam logic [19:0] FR_G = 20'h54321;
	localparam logic [19:0] FR_N = 20'h0dcba;

	logic                   sys_clk;
	logic                   rst;
	mtr_cmd_t               cmd;
	mtr_fill_t              fill;
	logic                   flushPinN;
	logic [`MTR_PAGE_W-1:0] lookupPage;
	logic [63:0]            rdData;
	logic                   rdValid;
	logic                   fault;
	mtr_memtype_t           memType;
	logic                   typeValid;
	logic                   rangesOn;
	logic                   fixedOn;
	logic [31:0]            featureWord;
	logic                   lookupHit;
	logic [`MTR_PAGE_W-1:0] lookupFrame;
	logic                   lookupGlobal;
	int                     errors;
	int                     checks_done;

	mtr_reg_row_t regRows [0:24] = '{
		'{MTR_OP_MODEL_RD, 12'h000, 64'h0, 1'b0, 64'h508},
		'{MTR_OP_MODEL_RD, 12'h001, 64'h0, 1'b0, 64'h0},
		'{MTR_OP_MODEL_RD, 12'h010, 64'h0, 1'b0, 64'h0},
		'{MTR_OP_MODEL_RD, 12'h02f, 64'h0, 1'b0, 64'h0},
		'{MTR_OP_MODEL_WR, 12'h000, 64'hffff, 1'b1, 64'h0},
		'{MTR_OP_MODEL_RD, 12'h000, 64'h0, 1'b0, 64'h508},
		'{MTR_OP_MODEL_RD, 12'h0ff, 64'h0, 1'b1, 64'h0},
		'{MTR_OP_MODEL_WR, 12'h001, 64'h100, 1'b1, 64'h0},
		'{MTR_OP_MODEL_WR, 12'h001, 64'h02, 1'b1, 64'h0},
		'{MTR_OP_MODEL_WR, 12'h001, 64'hc06, 1'b0, 64'h0},
		'{MTR_OP_MODEL_RD, 12'h001, 64'h0, 1'b0, 64'hc06},
		'{MTR_OP_MODEL_WR, 12'h010, 64'h0606_0605_0404_0100, 1'b0, 64'h0},
		'{MTR_OP_MODEL_RD, 12'h010, 64'h0, 1'b0, 64'h0606_0605_0404_0100},
		'{MTR_OP_MODEL_WR, 12'h011, 64'h0606_0606_0606_0602, 1'b1, 64'h0},
		'{MTR_OP_MODEL_RD, 12'h011, 64'h0, 1'b0, 64'h0},
		'{MTR_OP_MODEL_WR, 12'h020, 64'h07, 1'b1, 64'h0},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h00, 1'b0, 64'(MTR_MT_UNCACHEABLE)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h01, 1'b0, 64'(MTR_MT_WRITE_COMBINING)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h04, 1'b0, 64'(MTR_MT_WRITE_THROUGH)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h05, 1'b0, 64'(MTR_MT_WRITE_PROTECT)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h06, 1'b0, 64'(MTR_MT_WRITEBACK)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h02, 1'b1, 64'(MTR_MT_RESERVED)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h03, 1'b1, 64'(MTR_MT_RESERVED)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h07, 1'b1, 64'(MTR_MT_RESERVED)},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'hff, 1'b1, 64'(MTR_MT_RESERVED)}
	};

	// Op NONE stands for a flush-pin move to data[0]
	mtr_flush_row_t flushRows [0:19] = '{
		'{MTR_OP_PAGE_INV, 12'h0, {32'h0, PG_G, 12'h0}, 1'b0, 1'b1},
		'{MTR_OP_CR3_WR, 12'h0, 64'h1000, 1'b1, 1'b0},
		'{MTR_OP_TASK_SWITCH, 12'h0, 64'h1000, 1'b1, 1'b1},
		'{MTR_OP_TASK_SWITCH, 12'h0, 64'h2000, 1'b1, 1'b0},
		'{MTR_OP_NONE, 12'h0, 64'h0, 1'b0, 1'b0},
		'{MTR_OP_NONE, 12'h0, 64'h1, 1'b0, 1'b0},
		'{MTR_OP_MODEL_WR, 12'h020, 64'h06, 1'b0, 1'b0},
		'{MTR_OP_MODEL_WR, 12'h021, 64'hfff, 1'b0, 1'b0},
		'{MTR_OP_MODEL_WR, 12'h000, 64'h0, 1'b1, 1'b1},
		'{MTR_OP_MODEL_WR, 12'h001, 64'h100, 1'b1, 1'b1},
		'{MTR_OP_MODEL_RD, 12'h010, 64'h0, 1'b1, 1'b1},
		'{MTR_OP_CR0_WR, 12'h0, 64'h1, 1'b0, 1'b0},
		'{MTR_OP_CR0_WR, 12'h0, 64'h1, 1'b1, 1'b1},
		'{MTR_OP_CR0_WR, 12'h0, 64'h8000_0001, 1'b0, 1'b0},
		'{MTR_OP_CR4_WR, 12'h0, 64'h80, 1'b0, 1'b0},
		'{MTR_OP_CR4_WR, 12'h0, 64'h80, 1'b1, 1'b1},
		'{MTR_OP_CR4_WR, 12'h0, 64'h90, 1'b0, 1'b0},
		'{MTR_OP_CR4_WR, 12'h0, 64'hb0, 1'b0, 1'b0},
		'{MTR_OP_CR4_WR, 12'h0, 64'hb1, 1'b1, 1'b1},
		'{MTR_OP_TYPE_CHECK, 12'h0, 64'h06, 1'b1, 1'b1}
	};

	mtr_core_model core (
		.sys_clk    (sys_clk),
		.cmd        (cmd),
		.fill       (fill),
		.lookupPage (lookupPage),
		.flushPinN  (flushPinN)
	);

	mtr_top dut (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.cmd          (cmd),
		.flushPinN    (flushPinN),
		.fill         (fill),
		.lookupPage   (lookupPage),
		.rdData       (rdData),
		.rdValid      (rdValid),
		.fault        (fault),
		.memType      (memType),
		.typeValid    (typeValid),
		.rangesOn     (rangesOn),
		.fixedOn      (fixedOn),
		.featureWord  (featureWord),
		.lookupHit    (lookupHit),
		.lookupFrame  (lookupFrame),
		.lookupGlobal (lookupGlobal)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic probe(input logic [19:0] pg, input logic expHit, input logic [19:0] fr,
			input logic g);
		core.look(pg);
		@(negedge sys_clk);
		chk({63'h0, lookupHit}, {63'h0, expHit});
		if (expHit) begin
			chk({44'h0, lookupFrame}, {44'h0, fr});
			chk({63'h0, lookupGlobal}, {63'h0, g});
		end
	endtask

	task automatic reg_out(input mtr_op_t op, input logic [11:0] idx, input logic [63:0] exp);
		core.issue(op, idx, 64'h0);
		@(negedge sys_clk);
		chk({63'h0, rdValid}, 64'h1);
		chk(rdData, exp);
	endtask

	initial begin
		errors = 0;
		checks_done = 0;
		rst = 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk({62'h0, rangesOn, fixedOn}, 64'h0);
		chk({32'h0, featureWord}, 64'h1000);
		foreach (regRows[i]) begin
			core.issue(regRows[i].op, regRows[i].idx, regRows[i].data);
			@(negedge sys_clk);
			chk({63'h0, fault}, {63'h0, regRows[i].expFault});
			chk({63'h0, rdValid},
				{63'h0, regRows[i].op == MTR_OP_MODEL_RD && !regRows[i].expFault});
			chk({63'h0, typeValid}, {63'h0, regRows[i].op == MTR_OP_TYPE_CHECK});
			if (regRows[i].op == MTR_OP_MODEL_RD && !regRows[i].expFault)
				chk(rdData, regRows[i].expVal);
			if (regRows[i].op == MTR_OP_TYPE_CHECK)
				chk({61'h0, memType}, regRows[i].expVal);
		end
		chk({62'h0, rangesOn, fixedOn}, 64'h3);
		foreach (flushRows[i]) begin
			core.put(1'b1, PG_G, FR_G);
			core.put(1'b0, PG_N, FR_N);
			if (flushRows[i].op == MTR_OP_NONE)
				core.pin(flushRows[i].data[0]);
			else
				core.issue(flushRows[i].op, flushRows[i].idx, flushRows[i].data);
			probe(PG_G, flushRows[i].expG, FR_G, 1'b1);
			probe(PG_N, flushRows[i].expN, FR_N, 1'b0);
		end
		// Second reset in mid-run must drop the programmed map again
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk({62'h0, rangesOn, fixedOn}, 64'h0);
		chk({32'h0, featureWord}, 64'h1000);
		reg_out(MTR_OP_MODEL_RD, 12'h001, 64'h0);
		reg_out(MTR_OP_MODEL_RD, 12'h010, 64'h0);
		reg_out(MTR_OP_MODEL_RD, 12'h020, 64'h0);
		// Software puts back the fixed register 0x010 value written before the reset
		core.issue(MTR_OP_MODEL_WR, 12'h010, 64'h0606_0605_0404_0100);
		reg_out(MTR_OP_MODEL_RD, 12'h010, 64'h0606_0605_0404_0100);
		reg_out(MTR_OP_MODEL_RD, 12'h000, 64'h508);
		close_out();
	end

	// About 273 cycles are needed; allow over seventy times that
	initial begin
		#2000000;
		errors++;
		close_out();
	end
endmodule
